// >>> dv/papd_host_model.sv
// papd_host_model: host processor on the word register port.
// assumes requests start after reset and one access runs at a time.
`timescale 1ns/1ps
`default_nettype none
module papd_host_model
  import papd_pkg::*;
(
  // clock
  input  wire logic        core_clk_i,
  // answers
  input  wire logic [31:0] reg_rdata_i,
  input  wire logic        reg_ack_i,
  // requests
  output logic [15:0]      reg_addr_o,
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic [31:0]      reg_wdata_o
);
  // ==========================================================
  // idle levels at time zero
  initial begin
    reg_addr_o = 16'h0000;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 32'h00000000;
  end
  // write is taken at one edge, so the strobe lasts one cycle
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_o <= 1'b0;
  endtask : wr
  // read waits a bounded time; no answer leaves unknown data
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    d = 'x;
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk_i);
      reg_rd_o <= 1'b0;
      #1;
      if (reg_ack_i === 1'b1) begin
        d = reg_rdata_i;
        break;
      end
    end
  endtask : rd
  // start-up before the fundamental path is trusted
  task automatic setup();
    wr(OFS_VNOM, 32'h00400000);
    wr(OFS_CMODE, 32'h00000000);
  endtask : setup
endmodule : papd_host_model
`default_nettype wire

// >>> dv/papd_top_sva.sv
// papd_top_sva: port checks for the phase power datapath.
// assumes it is bound into papd_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module papd_top_sva
  import papd_pkg::*;
(
  // clock and reset
  input wire logic                    core_clk_i,
  input wire logic                    rst_i,
  // watched ports
  input wire logic                    sample_stb_i,
  input wire logic [15:0]             reg_addr_i,
  input wire logic                    reg_rd_i,
  input wire logic [31:0]             reg_rdata_o,
  input wire logic                    reg_ack_o,
  input wire logic                    power_valid_o,
  input wire logic signed [2:0][23:0] total_power_o,
  input wire logic signed [2:0][23:0] fund_power_o
);
  // ==========================================================
  // busy window after a taken strobe
  logic [2:0] busy;
  logic [2:0] next_busy;
  logic       taken;
  assign taken = sample_stb_i && (busy == 3'h0);
  // strobes inside the window are dropped, so do not count them
  always_comb begin
    next_busy = busy;
    if (taken) next_busy = 3'h5;
    else if (busy != 3'h0) next_busy = busy - 3'h1;
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) busy <= 3'h0;
    else busy <= next_busy;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // properties
  property p_valid_lat;
    taken |-> ##6 power_valid_o ##1 !power_valid_o;
  endproperty
  a_valid_lat: assert property (p_valid_lat) else $error("valid late");
  property p_valid_cause;
    power_valid_o |-> $past(taken, 6);
  endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("stray valid");
  property p_total_hold;
    !power_valid_o |-> $stable(total_power_o);
  endproperty
  a_total_hold: assert property (p_total_hold) else $error("total moved");
  property p_fund_hold;
    !power_valid_o |-> $stable(fund_power_o);
  endproperty
  a_fund_hold: assert property (p_fund_hold) else $error("fund moved");
  property p_ack_rd;
    reg_rd_i |=> reg_ack_o;
  endproperty
  a_ack_rd: assert property (p_ack_rd) else $error("no read ack");
  property p_ack_cause;
    reg_ack_o |-> $past(reg_rd_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_rdata_hold;
    !reg_ack_o |-> $stable(reg_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
  property p_gain_pad;
    reg_ack_o && ($past(reg_addr_i) inside {[OFS_A_GAIN:OFS_C_TOS],
      [OFS_A_FOS:OFS_C_FOS]}) |->
      reg_rdata_o[31:24] == {4'h0, {4{reg_rdata_o[23]}}};
  endproperty
  a_gain_pad: assert property (p_gain_pad) else $error("bad pad");
  property p_vnom_pad;
    reg_ack_o && $past(reg_addr_i) == OFS_VNOM |->
      reg_rdata_o[31:28] == 4'h0;
  endproperty
  a_vnom_pad: assert property (p_vnom_pad) else $error("bad vl");
  property p_inst_sext;
    reg_ack_o && ($past(reg_addr_i) inside {[OFS_A_INST:OFS_C_INST]})
      |-> reg_rdata_o[31:24] == {8{reg_rdata_o[23]}};
  endproperty
  a_inst_sext: assert property (p_inst_sext) else $error("bad sext");
  // main scenarios reached
  c_taken: cover property (taken);
  c_valid: cover property (power_valid_o);
  c_read: cover property (reg_ack_o);
endmodule : papd_top_sva
bind papd_top papd_top_sva u_sva (
  .core_clk_i    (core_clk_i),
  .rst_i         (rst_i),
  .sample_stb_i  (sample_stb_i),
  .reg_addr_i    (reg_addr_i),
  .reg_rd_i      (reg_rd_i),
  .reg_rdata_o   (reg_rdata_o),
  .reg_ack_o     (reg_ack_o),
  .power_valid_o (power_valid_o),
  .total_power_o (total_power_o),
  .fund_power_o  (fund_power_o)
);
`default_nettype wire

// >>> dv/papd_top_tb.sv
// papd_top_tb: self-checking bench for the phase power datapath.
// assumes papd_pkg, the host model and the bound checker are built.
`timescale 1ns/1ps
`default_nettype none
module papd_top_tb;
  import papd_pkg::*;
  // ==========================================================
  // constants and signals
  localparam int     CYC_MAX = 80000;
  localparam longint FS_PWR  = 'h19BDAA7;
  logic                    core_clk_i;
  logic                    rst_i;
  logic                    sample_stb_i;
  logic signed [2:0][23:0] volt_i;
  logic signed [2:0][23:0] curr_i;
  logic [15:0]             reg_addr;
  logic                    reg_wr;
  logic                    reg_rd;
  logic [31:0]             reg_wdata;
  logic [31:0]             reg_rdata;
  logic                    reg_ack;
  logic                    power_valid;
  logic signed [2:0][23:0] total_power;
  logic signed [2:0][23:0] fund_power;
  int                      n_fail;
  int                      samples_checked;
  int                      cyc;
  logic [15:0]             rw_ofs [10];
  papd_top dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .sample_stb_i(sample_stb_i), .volt_i(volt_i), .curr_i(curr_i),
    .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .reg_ack_o(reg_ack), .power_valid_o(power_valid),
    .total_power_o(total_power), .fund_power_o(fund_power));
  papd_host_model u_host (.core_clk_i(core_clk_i),
    .reg_rdata_i(reg_rdata), .reg_ack_i(reg_ack), .reg_addr_o(reg_addr),
    .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_wdata_o(reg_wdata));
  // ==========================================================
  // helpers
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  // a hang ends the run through the same report
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc >= CYC_MAX) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [31:0] sx(input logic [23:0] v);
    return {{8{v[23]}}, v};
  endfunction : sx
  // filter output only nears its end value, so allow 2 percent
  function automatic logic [31:0] near(input logic [31:0] s,
                                       input longint e);
    longint d;
    if ($isunknown(s)) return 32'h0;
    d = longint'(signed'(s)) - e;
    if (d < 0) d = -d;
    return (d <= (e < 0 ? -e : e) / 50 + 256) ? 32'h1 : 32'h0;
  endfunction : near
  task automatic run_samples(input int n);
    repeat (n) begin
      @(posedge core_clk_i);
      sample_stb_i <= 1'b1;
      @(posedge core_clk_i);
      sample_stb_i <= 1'b0;
      repeat (6) @(posedge core_clk_i);
    end
  endtask : run_samples
  // ==========================================================
  // scenarios
  task automatic t_reset_values();
    logic [31:0] d;
    for (int k = 0; k < 10; k++) begin
      u_host.rd(rw_ofs[k], d);
      check("reset value", d, 32'h00000000);
    end
    u_host.rd(16'h1234, d);
    check("unmapped read", d, 32'h00000000);
  endtask : t_reset_values
  // negative pattern reads back as 28-bit signed in 32 bits
  task automatic t_formats();
    logic [31:0] d;
    for (int k = 0; k < 10; k++) begin
      u_host.wr(rw_ofs[k], 32'hFF876543);
      u_host.rd(rw_ofs[k], d);
      check("negative word", d, 32'h0F876543);
      u_host.wr(rw_ofs[k], 32'h00123456);
      u_host.rd(rw_ofs[k], d);
      check("positive word", d, 32'h00123456);
      u_host.wr(rw_ofs[k], 32'h00000000);
    end
  endtask : t_formats
  // dc full scale on A and B, total offset on C, fundamental offsets on A and C
  task automatic t_power();
    logic [31:0] d;
    volt_i <= {24'h000000, 24'h396690, 24'h396690};
    curr_i <= {24'h000000, 24'h396690, 24'h396690};
    u_host.setup();
    u_host.wr(OFS_A_GAIN, 32'h00C00000);
    u_host.wr(OFS_B_GAIN, 32'h00400000);
    u_host.wr(OFS_C_TOS, 32'h00100000);
    u_host.wr(OFS_A_FOS, 32'h00100000);
    u_host.wr(OFS_C_FOS, 32'h00080000);
    run_samples(6000);
    check("total A", near(sx(total_power[0]), FS_PWR / 32), 32'h1);
    check("total B", near(sx(total_power[1]), FS_PWR * 3 / 32), 32'h1);
    check("total C", near(sx(total_power[2]), 'h10000), 32'h1);
    check("fund A", near(sx(fund_power[0]), 'h8000), 32'h1);
    check("fund B", near(sx(fund_power[1]), 0), 32'h1);
    check("fund C", near(sx(fund_power[2]), 'h8000), 32'h1);
    u_host.rd(OFS_B_INST, d);
    check("inst B reg", near(d, FS_PWR * 3 / 32), 32'h1);
    u_host.rd(OFS_C_INST, d);
    check("inst C reg", near(d, 'h10000), 32'h1);
  endtask : t_power
  task automatic t_mode_bits();
    logic [31:0] d;
    u_host.wr(OFS_CMODE, 32'h00004000);
    u_host.rd(OFS_CMODE, d);
    check("freq select", d, 32'h00004000);
    u_host.wr(OFS_CONFIG, 32'h00000020);
    u_host.rd(OFS_CONFIG, d);
    check("filter select", d, 32'h00000020);
    run_samples(64);
    check("strong A", near(sx(total_power[0]), FS_PWR / 32), 32'h1);
    check("60 Hz fund A", near(sx(fund_power[0]), 'h8000), 32'h1);
  endtask : t_mode_bits
  // ==========================================================
  // main sequence
  initial begin
    rw_ofs = '{OFS_A_GAIN, OFS_B_GAIN, OFS_C_GAIN, OFS_A_TOS, OFS_B_TOS,
               OFS_C_TOS, OFS_VNOM, OFS_A_FOS, OFS_B_FOS, OFS_C_FOS};
    n_fail = 0;
    samples_checked = 0;
    cyc = 0;
    rst_i = 1'b1;
    sample_stb_i = 1'b0;
    volt_i = '0;
    curr_i = '0;
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_formats();
    t_power();
    t_mode_bits();
    wrap_up();
  end
endmodule : papd_top_tb
`default_nettype wire

// >>> rtl/papd_chan_if.sv
// papd_chan_if: links the sequencer to one power channel.
// assumes the sequencer and channel share core_clk_i.
`timescale 1ns/1ps
`default_nettype none
interface papd_chan_if;
  import papd_pkg::*;
  papd_state_t        step;
  logic               lpf_strong;
  logic signed [23:0] volt;
  logic signed [23:0] curr;
  logic signed [23:0] gain;
  logic signed [23:0] offset;
  logic signed [29:0] power;
  modport ctrl (output step, lpf_strong, volt, curr, gain, offset,
                input  power);
  modport chan (input  step, lpf_strong, volt, curr, gain, offset,
                output power);
endinterface : papd_chan_if
`default_nettype wire

// >>> rtl/papd_fund_bpf.sv
// papd_fund_bpf: two-pole resonator keeping the first harmonic of a sample.
// assumes sample_stb_i is a one-cycle pulse at the 8 kHz sample rate.
`timescale 1ns/1ps
`default_nettype none
module papd_fund_bpf (
  // clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               rst_i,
  // samples
  input  wire logic               sample_stb_i,
  input  wire logic               freq_60_i,
  input  wire logic signed [23:0] x_i,
  output logic signed [23:0]      y_o
);
  import papd_pkg::*;

  logic signed [31:0] y1, y2, next_y1, next_y2;
  logic signed [23:0] x1, x2, next_x1, next_x2;
  logic signed [17:0] coef;
  logic signed [51:0] acc;

  // resonator update; harmonics fall well outside the narrow passband
  always_comb begin
    coef    = freq_60_i ? BPF_C60 : BPF_C50;
    acc     = 52'(coef * y1) - 52'(BPF_R2 * y2)
            + 52'(BPF_G * 25'(25'(x_i) - 25'(x2)));
    next_y1 = y1;
    next_y2 = y2;
    next_x1 = x1;
    next_x2 = x2;
    if (sample_stb_i) begin
      next_y1 = 32'(acc >>> BPF_FRAC);
      next_y2 = y1;
      next_x1 = x_i;
      next_x2 = x1;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      y1 <= '0;
      y2 <= '0;
      x1 <= '0;
      x2 <= '0;
    end else begin
      y1 <= next_y1;
      y2 <= next_y2;
      x1 <= next_x1;
      x2 <= next_x2;
    end
  end

  assign y_o = 24'(y1);

endmodule : papd_fund_bpf
`default_nettype wire

// >>> rtl/papd_pkg.sv
// papd_pkg: constants and types shared by the phase active power datapath.
// assumes one dsp clock; register offsets are word addresses on the
// device's internal register port.
package papd_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [15:0] OFS_A_GAIN    = 16'h4399;
  localparam logic [15:0] OFS_B_GAIN    = 16'h439A;
  localparam logic [15:0] OFS_C_GAIN    = 16'h439B;
  localparam logic [15:0] OFS_A_TOS     = 16'h439C;
  localparam logic [15:0] OFS_B_TOS     = 16'h439D;
  localparam logic [15:0] OFS_C_TOS     = 16'h439E;
  localparam logic [15:0] OFS_VNOM      = 16'h43A2;
  localparam logic [15:0] OFS_A_FOS     = 16'h43A3;
  localparam logic [15:0] OFS_B_FOS     = 16'h43A4;
  localparam logic [15:0] OFS_C_FOS     = 16'h43A5;
  localparam logic [15:0] OFS_A_INST    = 16'hE518;
  localparam logic [15:0] OFS_B_INST    = 16'hE519;
  localparam logic [15:0] OFS_C_INST    = 16'hE51A;
  localparam logic [15:0] OFS_CMODE     = 16'hE60E;
  localparam logic [15:0] OFS_CONFIG    = 16'hE618;

  // ==========================================================================
  // field positions and reset values
  localparam int          LPF_SEL_BIT   = 5;
  localparam int          FREQ_SEL_BIT  = 14;
  localparam logic [23:0] WORD24_RST    = 24'h000000;
  localparam logic [27:0] VNOM_RST      = 28'h0000000;
  localparam logic [15:0] CTRL16_RST    = 16'h0000;

  // ==========================================================================
  // datapath scaling
  localparam int PROD_SHIFT = 19;  // full scale in-phase dc lands on 26991271
  localparam int INST_SHIFT = 4;
  localparam int GAIN_FRAC  = 23;
  localparam int LPF_SHIFT  = 10;  // pole at 8 kHz sample rate
  localparam int LPF_FRAC   = 16;
  localparam int BPF_FRAC   = 14;

  // fundamental band-pass coefficients, q14, pole radius 0.99
  localparam logic signed [17:0] BPF_C50 = 18'sh07E55;
  localparam logic signed [17:0] BPF_C60 = 18'sh07E28;
  localparam logic signed [17:0] BPF_R2  = 18'sh03EBA;
  localparam logic signed [17:0] BPF_G   = 18'sh000A3;

  // ==========================================================================
  // sample sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_MUL  = 6'h02,
    ST_FLT1 = 6'h04,
    ST_FLT2 = 6'h08,
    ST_GAIN = 6'h10,
    ST_LOAD = 6'h20
  } papd_state_t;

endpackage : papd_pkg

// >>> rtl/papd_power_chan.sv
// papd_power_chan: multiply, offset, low-pass and gain for one power path.
// assumes the sequencer steps it through one state per cycle per sample.
`timescale 1ns/1ps
`default_nettype none
module papd_power_chan (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // sequencer link
  papd_chan_if.chan ch
);
  import papd_pkg::*;

  logic signed [29:0] prod, next_prod;
  logic signed [45:0] acc1, acc2, next_acc1, next_acc2;
  logic signed [29:0] power, next_power;
  logic signed [47:0] full_prod;
  logic signed [45:0] x_ext;
  logic signed [29:0] y;
  logic signed [53:0] gp;

  // one stage per step keeps each multiplier off the others' paths
  always_comb begin
    full_prod  = ch.volt * ch.curr;
    x_ext      = $signed({prod, 16'h0000});
    y          = 30'(acc2 >>> LPF_FRAC);
    gp         = y * ch.gain;
    next_prod  = prod;
    next_acc1  = acc1;
    next_acc2  = acc2;
    next_power = power;
    case (ch.step)
      ST_MUL:  next_prod = 30'(full_prod >>> PROD_SHIFT)
                         + 30'(ch.offset);
      ST_FLT1: next_acc1 = acc1 + ((x_ext - acc1) >>> LPF_SHIFT);
      // strong mode cascades a second pole: slower, far more ripple loss
      ST_FLT2: next_acc2 = ch.lpf_strong
                         ? acc2 + ((acc1 - acc2) >>> LPF_SHIFT)
                         : acc1;
      ST_GAIN: next_power = y + 30'(gp >>> GAIN_FRAC);
      default: next_prod = prod;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prod  <= '0;
      acc1  <= '0;
      acc2  <= '0;
      power <= '0;
    end else begin
      prod  <= next_prod;
      acc1  <= next_acc1;
      acc2  <= next_acc2;
      power <= next_power;
    end
  end

  assign ch.power = power;

endmodule : papd_power_chan
`default_nettype wire

// >>> rtl/papd_top.sv
// papd_top: per-phase total and fundamental active power datapath.
// assumes samples come from the adc chains on core_clk_i and that the
// serial host ports reach the registers through the word register port.
//
// Contract
// - each phase power is current sample times voltage sample
// - average active power is the low-passed dc part of that product
// - strength bit 5 at zero gives the lighter 650 ms filter
// - strength bit set gives the stronger 1300 ms filter
// - total power keeps all harmonics, fundamental keeps first harmonic only
// - full-scale in-phase inputs filter to 26991271
// - instantaneous power register is 24 bits, filter output over 16
// - total instantaneous power registers read through the host register port; fundamental ones only on fund_power_o
// - bit 14 picks 50 Hz or 60 Hz for fundamental power
// - fundamental power settles within 375 ms or 875 ms
// - nominal voltage reads as 32 bits, top four bits zero
// - filtered power scaled by one plus gain over 2^23
// - one phase gain applies to every power path of that phase
// - gain 0xC00000 halves power, 0x400000 raises it by half
// - gain and offsets read sign-extended to 28 bits, zero-padded to 32
// - each phase has separate total and fundamental 24-bit offsets
// - one offset unit weighs one multiplier output unit
`timescale 1ns/1ps
`default_nettype none
module papd_top (
  // clock and reset
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_i,
  // adc sample inputs
  input  wire logic                     sample_stb_i,
  input  wire logic signed [2:0][23:0]  volt_i,
  input  wire logic signed [2:0][23:0]  curr_i,
  // register port
  input  wire logic [15:0]              reg_addr_i,
  input  wire logic                     reg_wr_i,
  input  wire logic                     reg_rd_i,
  input  wire logic [31:0]              reg_wdata_i,
  output logic [31:0]                   reg_rdata_o,
  output logic                          reg_ack_o,
  // power results
  output logic                          power_valid_o,
  output logic signed [2:0][23:0]       total_power_o,
  output logic signed [2:0][23:0]       fund_power_o
);
  import papd_pkg::*;

  // ==========================================================================
  // register file
  logic signed [2:0][23:0] gain, next_gain;
  logic signed [2:0][23:0] tos, next_tos;
  logic signed [2:0][23:0] fos, next_fos;
  logic [27:0]             vnom, next_vnom;
  logic [15:0]             cmode, next_cmode;
  logic [15:0]             config_r, next_config;
  logic                    lpf_strong;
  logic                    freq_60;

  assign lpf_strong = config_r[LPF_SEL_BIT];
  assign freq_60    = cmode[FREQ_SEL_BIT];

  // writes take the low bits; wider host words are truncated
  always_comb begin
    next_gain     = gain;
    next_tos      = tos;
    next_fos      = fos;
    next_vnom     = vnom;
    next_cmode    = cmode;
    next_config   = config_r;
    if (reg_wr_i) begin
      case (reg_addr_i)
        OFS_A_GAIN:   next_gain[0]  = reg_wdata_i[23:0];
        OFS_B_GAIN:   next_gain[1]  = reg_wdata_i[23:0];
        OFS_C_GAIN:   next_gain[2]  = reg_wdata_i[23:0];
        OFS_A_TOS:    next_tos[0]   = reg_wdata_i[23:0];
        OFS_B_TOS:    next_tos[1]   = reg_wdata_i[23:0];
        OFS_C_TOS:    next_tos[2]   = reg_wdata_i[23:0];
        OFS_A_FOS:    next_fos[0]   = reg_wdata_i[23:0];
        OFS_B_FOS:    next_fos[1]   = reg_wdata_i[23:0];
        OFS_C_FOS:    next_fos[2]   = reg_wdata_i[23:0];
        OFS_VNOM:     next_vnom     = reg_wdata_i[27:0];
        OFS_CMODE:    next_cmode    = reg_wdata_i[15:0];
        OFS_CONFIG:   next_config   = reg_wdata_i[15:0];
        default:      next_vnom     = vnom;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gain     <= {3{WORD24_RST}};
      tos      <= {3{WORD24_RST}};
      fos      <= {3{WORD24_RST}};
      vnom     <= VNOM_RST;
      cmode    <= CTRL16_RST;
      config_r <= CTRL16_RST;
    end else begin
      gain     <= next_gain;
      tos      <= next_tos;
      fos      <= next_fos;
      vnom     <= next_vnom;
      cmode    <= next_cmode;
      config_r <= next_config;
    end
  end

  // ==========================================================================
  // sample sequencer
  papd_state_t state, next_state;

  // one sample walks mul, two filter poles, gain, load; a strobe that
  // arrives before load finishes is dropped, fine at 2500 cycles/sample
  always_comb begin
    case (state)
      ST_IDLE: next_state = sample_stb_i ? ST_MUL : ST_IDLE;
      ST_MUL:  next_state = ST_FLT1;
      ST_FLT1: next_state = ST_FLT2;
      ST_FLT2: next_state = ST_GAIN;
      ST_GAIN: next_state = ST_LOAD;
      ST_LOAD: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // raw sample capture
  logic signed [2:0][23:0] volt_s, next_volt_s;
  logic signed [2:0][23:0] curr_s, next_curr_s;

  // held for the whole walk so a new adc word cannot tear the product
  always_comb begin
    next_volt_s = volt_s;
    next_curr_s = curr_s;
    if (sample_stb_i && state == ST_IDLE) begin
      next_volt_s = volt_i;
      next_curr_s = curr_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      volt_s <= '0;
      curr_s <= '0;
    end else begin
      volt_s <= next_volt_s;
      curr_s <= next_curr_s;
    end
  end

  // ==========================================================================
  // per-phase channels
  logic signed [2:0][29:0] tot_pw;
  logic signed [2:0][29:0] fnd_pw;
  logic                    bpf_stb;

  assign bpf_stb = sample_stb_i && (state == ST_IDLE);

  generate
    for (genvar p = 0; p < 3; p++) begin : g_phase
      papd_chan_if tot_if ();
      papd_chan_if fnd_if ();
      logic signed [23:0] volt_f;
      logic signed [23:0] curr_f;

      // first-harmonic extraction feeds only the fundamental path
      papd_fund_bpf u_bpf_v (
        .core_clk_i   (core_clk_i),
        .rst_i        (rst_i),
        .sample_stb_i (bpf_stb),
        .freq_60_i    (freq_60),
        .x_i          (volt_i[p]),
        .y_o          (volt_f)
      );
      papd_fund_bpf u_bpf_i (
        .core_clk_i   (core_clk_i),
        .rst_i        (rst_i),
        .sample_stb_i (bpf_stb),
        .freq_60_i    (freq_60),
        .x_i          (curr_i[p]),
        .y_o          (curr_f)
      );

      // total path sees raw samples, so every harmonic contributes
      assign tot_if.step       = state;
      assign tot_if.lpf_strong = lpf_strong;
      assign tot_if.volt       = volt_s[p];
      assign tot_if.curr       = curr_s[p];
      assign tot_if.gain       = gain[p];
      assign tot_if.offset     = tos[p];
      assign tot_pw[p]         = tot_if.power;

      assign fnd_if.step       = state;
      assign fnd_if.lpf_strong = lpf_strong;
      assign fnd_if.volt       = volt_f;
      assign fnd_if.curr       = curr_f;
      assign fnd_if.gain       = gain[p];
      assign fnd_if.offset     = fos[p];
      assign fnd_pw[p]         = fnd_if.power;

      papd_power_chan u_tot (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .ch         (tot_if.chan)
      );
      papd_power_chan u_fnd (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .ch         (fnd_if.chan)
      );
    end
  endgenerate

  // ==========================================================================
  // instantaneous power registers
  logic signed [2:0][23:0] inst_tot, next_inst_tot;
  logic signed [2:0][23:0] inst_fnd, next_inst_fnd;
  logic                    pvalid, next_pvalid;

  // full-scale 26991271 over 16 still fits the 24-bit word
  always_comb begin
    next_inst_tot = inst_tot;
    next_inst_fnd = inst_fnd;
    next_pvalid   = 1'b0;
    if (state == ST_LOAD) begin
      for (int p = 0; p < 3; p++) begin
        next_inst_tot[p] = 24'(tot_pw[p] >>> INST_SHIFT);
        next_inst_fnd[p] = 24'(fnd_pw[p] >>> INST_SHIFT);
      end
      next_pvalid = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      inst_tot <= '0;
      inst_fnd <= '0;
      pvalid   <= 1'b0;
    end else begin
      inst_tot <= next_inst_tot;
      inst_fnd <= next_inst_fnd;
      pvalid   <= next_pvalid;
    end
  end

  assign total_power_o = inst_tot;
  assign fund_power_o  = inst_fnd;
  assign power_valid_o = pvalid;

  // ==========================================================================
  // register readback
  logic [31:0] rdata, next_rdata;
  logic        ack, next_ack;

  // host words: dsp 28-bit form with a zero top nibble
  function automatic logic [31:0] pad24(input logic [23:0] v);
    pad24 = {4'h0, {4{v[23]}}, v};
  endfunction : pad24

  // unmapped addresses answer zero so a host scan never hangs
  always_comb begin
    next_rdata = rdata;
    next_ack   = 1'b0;
    if (reg_rd_i) begin
      next_ack = 1'b1;
      case (reg_addr_i)
        OFS_A_GAIN:   next_rdata = pad24(gain[0]);
        OFS_B_GAIN:   next_rdata = pad24(gain[1]);
        OFS_C_GAIN:   next_rdata = pad24(gain[2]);
        OFS_A_TOS:    next_rdata = pad24(tos[0]);
        OFS_B_TOS:    next_rdata = pad24(tos[1]);
        OFS_C_TOS:    next_rdata = pad24(tos[2]);
        OFS_A_FOS:    next_rdata = pad24(fos[0]);
        OFS_B_FOS:    next_rdata = pad24(fos[1]);
        OFS_C_FOS:    next_rdata = pad24(fos[2]);
        OFS_VNOM:     next_rdata = {4'h0, vnom};
        OFS_A_INST:   next_rdata = {{8{inst_tot[0][23]}}, inst_tot[0]};
        OFS_B_INST:   next_rdata = {{8{inst_tot[1][23]}}, inst_tot[1]};
        OFS_C_INST:   next_rdata = {{8{inst_tot[2][23]}}, inst_tot[2]};
        OFS_CMODE:    next_rdata = {16'h0000, cmode};
        OFS_CONFIG:   next_rdata = {16'h0000, config_r};
        default:      next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata <= 32'h00000000;
      ack   <= 1'b0;
    end else begin
      rdata <= next_rdata;
      ack   <= next_ack;
    end
  end

  assign reg_rdata_o = rdata;
  assign reg_ack_o   = ack;

endmodule : papd_top
`default_nettype wire
